// File: girc_pkg.sv
`default_nettype none
package girc_pkg;
  localparam int          GIRC_ADDR_W       = 16;
  localparam int          GIRC_PORTS        = 7;
  localparam logic [15:0] GIRC_ADDR_REV     = 16'h0003;
  localparam logic [15:0] GIRC_ADDR_PWR     = 16'h0006;
  localparam logic [15:0] GIRC_ADDR_GSTAT   = 16'h0010;
  localparam logic [15:0] GIRC_ADDR_GMASK   = 16'h0014;
  localparam logic [15:0] GIRC_ADDR_PSTAT   = 16'h0018;
  localparam logic [15:0] GIRC_ADDR_PMASK   = 16'h001c;
  localparam int          GIRC_BIT_SRST     = 0;
  localparam int          GIRC_BIT_PWR_POL  = 0;
  localparam int          GIRC_BIT_PWR_EN   = 1;
  localparam int          GIRC_REV_LSB      = 4;
  localparam logic [3:0]  GIRC_REV_DEFAULT  = 4'h1;
  localparam logic [7:0]  GIRC_BYTE_ZERO    = 8'h00;
  localparam logic [1:0]  GIRC_BYTE_MSB     = 2'h0;
  localparam logic [1:0]  GIRC_BYTE_LSB     = 2'h3;
  localparam logic [6:0]  GIRC_PMASK_RST    = 7'h00;
  localparam logic [1:0]  GIRC_GMASK_RST    = 2'h0;
  localparam logic [1:0]  GIRC_PWR_RST      = 2'h0;
  localparam int          GIRC_SYNC_STAGES  = 2;
endpackage
`default_nettype wire

// File: girc_sync.sv
`default_nettype none
module girc_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         nrst,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// File: girc_top.sv
// Functional notes
// - revision nibble in bits 7:4 of byte 0x0003; bits 3:1 reserved, read zero
// - soft reset bit one holds data path reset, registers untouched
// - soft reset bit never self-clears; host writes zero to release
// - power event output driven only while its enable bit is one
// - global status bit 31 mirrors lookup engine pending request
// - global status bit 30 set by gpio trigger or timestamp units
// - per-port egress timestamp requests stay out of bit 30
// - global mask bits 31 and 30, one disables, reset zero
// - port summary status bits 6:0 for ports 7..1, upper bits zero
// - each port summary bit mirrors that port's pending status
// - port mask bits 6:0 writable, one disables, reset zero
// - byte addressed, big-endian multi-byte registers, any byte order
`default_nettype none
module girc_top
  import girc_pkg::*;
#(
  parameter int         NPORTS   = girc_pkg::GIRC_PORTS,
  parameter logic [3:0] REVISION = girc_pkg::GIRC_REV_DEFAULT
) (
  input  wire logic                               clock,
  input  wire logic                               nrst,
  input  wire logic                               reg_wr,
  input  wire logic                               reg_rd,
  input  wire logic [girc_pkg::GIRC_ADDR_W-1:0]   reg_addr,
  input  wire logic [7:0]                         reg_wdata,
  output var  logic [7:0]                         reg_rdata,
  input  wire logic                               lookup_engine_irq,
  input  wire logic                               gpio_trig_irq,
  input  wire logic                               gpio_ts_irq,
  input  wire logic [NPORTS-1:0]                  port_irq,
  input  wire logic                               power_event_req,
  output var  logic                               power_event_output,
  output var  logic                               power_event_output_oe_n,
  output var  logic                               irq_out_n,
  output var  logic                               datapath_rst_n
);
  import girc_pkg::*;

  logic              srst_reg;
  logic [1:0]        pwr_reg;
  logic [1:0]        gmask_reg;
  logic [NPORTS-1:0] pmask_reg;
  logic [1:0]        gstat_reg;
  logic [NPORTS-1:0] pstat_reg;
  logic [3:0]        sync_in;
  logic [3:0]        sync_out;
  logic [NPORTS-1:0] port_sync;

  // lookup, gpio and power event sources pass a two-stage synchronizer; port_irq is used directly
  assign sync_in = {lookup_engine_irq, gpio_trig_irq, gpio_ts_irq,
                    power_event_req};
  girc_sync #(.W(4)) u_sync (
    .clock (clock),
    .nrst  (nrst),
    .d     (sync_in),
    .q     (sync_out)
  );
  assign port_sync = port_irq;

  // byte decode, big-endian: lowest address holds bits 31:24
  wire [15:0] word_base = {reg_addr[15:2], 2'b00};
  wire [1:0]  byte_sel  = reg_addr[1:0];
  wire [4:0]  shift     = 5'((GIRC_BYTE_LSB - byte_sel) * 8);
  wire        hit_rev   = reg_addr == GIRC_ADDR_REV;
  wire        hit_pwr   = reg_addr == GIRC_ADDR_PWR;
  wire        hit_gstat = word_base == GIRC_ADDR_GSTAT;
  wire        hit_gmask = word_base == GIRC_ADDR_GMASK;
  wire        hit_pstat = word_base == GIRC_ADDR_PSTAT;
  wire        hit_pmask = word_base == GIRC_ADDR_PMASK;

  wire [31:0] gstat_word = {gstat_reg, 30'h0};
  wire [31:0] gmask_word = {gmask_reg, 30'h0};
  wire [31:0] pstat_word = {{(32-NPORTS){1'b0}}, pstat_reg};
  wire [31:0] pmask_word = {{(32-NPORTS){1'b0}}, pmask_reg};

  wire [31:0] wr_word  = {24'h0, reg_wdata} << shift;
  wire [31:0] wr_lane  = 32'h0000_00ff << shift;
  wire [31:0] gmask_nx = (gmask_word & ~wr_lane) | (wr_word & wr_lane);
  wire [31:0] pmask_nx = (pmask_word & ~wr_lane) | (wr_word & wr_lane);

  wire [31:0] rd_word =
    hit_gstat ? gstat_word :
    hit_gmask ? gmask_word :
    hit_pstat ? pstat_word :
    hit_pmask ? pmask_word : 32'h0;
  wire [7:0] rd_byte = 8'(rd_word >> shift);
  wire [7:0] rev_byte = {REVISION, 3'h0, srst_reg};
  wire [7:0] pwr_byte = {6'h0, pwr_reg};
  wire [7:0] rdata_next =
    hit_rev ? rev_byte :
    hit_pwr ? pwr_byte : rd_byte;

  // status summaries; egress timestamp requests arrive via port_irq only
  wire [1:0] gstat_next = {sync_out[3],
                           sync_out[2] | sync_out[1]};
  wire irq_next = |(gstat_reg & ~gmask_reg) |
                  |(pstat_reg & ~pmask_reg);
  wire pwr_active = sync_out[0];

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      srst_reg <= 1'b0;
      pwr_reg  <= GIRC_PWR_RST;
      gmask_reg <= GIRC_GMASK_RST;
      pmask_reg <= '0;
    end else if (reg_wr) begin
      if (hit_rev)
        srst_reg <= reg_wdata[GIRC_BIT_SRST];
      if (hit_pwr)
        pwr_reg <= reg_wdata[1:0];
      if (hit_gmask)
        gmask_reg <= gmask_nx[31:30];
      if (hit_pmask)
        pmask_reg <= pmask_nx[NPORTS-1:0];
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      gstat_reg <= 2'b00;
      pstat_reg <= '0;
      irq_out_n <= 1'b1;
      reg_rdata <= GIRC_BYTE_ZERO;
      datapath_rst_n <= 1'b0;
      power_event_output <= 1'b0;
      power_event_output_oe_n <= 1'b1;
    end else begin
      gstat_reg <= gstat_next;
      pstat_reg <= port_sync;
      irq_out_n <= ~irq_next;
      if (reg_rd)
        reg_rdata <= rdata_next;
      datapath_rst_n <= ~srst_reg;
      power_event_output <= pwr_active ? pwr_reg[GIRC_BIT_PWR_POL]
                                       : ~pwr_reg[GIRC_BIT_PWR_POL];
      power_event_output_oe_n <= ~pwr_reg[GIRC_BIT_PWR_EN];
    end
  end
endmodule
`default_nettype wire

// File: girc_properties.sv
`default_nettype none
module girc_properties #(
  parameter int         NPORTS   = 7,
  parameter logic [3:0] REVISION = 4'h1
) (
  input  wire logic              clock,
  input  wire logic              nrst,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [15:0]       reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic [7:0]        reg_rdata,
  input  wire logic              lookup_engine_irq,
  input  wire logic              gpio_trig_irq,
  input  wire logic              gpio_ts_irq,
  input  wire logic [NPORTS-1:0] port_irq,
  input  wire logic              power_event_output_oe_n,
  input  wire logic              irq_out_n,
  input  wire logic              datapath_rst_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] quiet_reg;
  wire        busy = lookup_engine_irq | gpio_trig_irq | gpio_ts_irq |
                     (|port_irq);
  wire        wr3  = reg_wr && reg_addr == 16'h0003;
  wire        wr6  = reg_wr && reg_addr == 16'h0006;
  // counts cycles with every source idle
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) quiet_reg <= 3'h0;
    else quiet_reg <= busy ? 3'h0 : quiet_reg + {2'h0, quiet_reg != 3'h7};
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  soft_reset_a: assert property (
    wr3 |-> ##2 datapath_rst_n == !$past(reg_wdata[0], 2))
    else $error("soft reset bit not applied");
  no_self_clear_a: assert property (
    !datapath_rst_n && $past(nrst) && !wr3 && !$past(wr3)
    |=> !datapath_rst_n)
    else $error("soft reset released without write");
  pwr_enable_a: assert property (
    wr6 |-> ##2 power_event_output_oe_n == !$past(reg_wdata[1], 2))
    else $error("power event enable wrong");
  revision_a: assert property (
    reg_rd && reg_addr == 16'h0003 |=> reg_rdata[7:1] == {REVISION, 3'h0})
    else $error("revision byte wrong");
  gstat_low_a: assert property (
    reg_rd && reg_addr == 16'h0013 |=> reg_rdata == 8'h00)
    else $error("global status low byte not zero");
  port_stat_a: assert property (
    reg_rd && reg_addr == 16'h001b && $stable(port_irq)
    |=> reg_rdata == {1'b0, $past(port_irq)})
    else $error("port summary differs");
  port_mask_a: assert property (
    (reg_wr && reg_addr == 16'h001f) ##1 (reg_rd && reg_addr == 16'h001f)
    |=> reg_rdata == {1'b0, $past(reg_wdata[6:0], 2)})
    else $error("port mask readback differs");
  irq_idle_a: assert property (quiet_reg == 3'h7 |-> irq_out_n)
    else $error("interrupt without source");
endmodule
`default_nettype wire

// File: girc_host.sv
`default_nettype none
module girc_host (
  input  wire logic        clock,
  output var  logic        reg_wr,
  output var  logic        reg_rd,
  output var  logic [15:0] reg_addr,
  output var  logic [7:0]  reg_wdata,
  input  wire logic [7:0]  reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // one byte per access, any order
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    reg_rd = 1'b0;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clock);
    #1;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clock);
    #1;
    d = reg_rdata;
  endtask
  task automatic idle();
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 16'hffff;
    reg_wdata = 8'h5a;
    @(posedge clock);
    #1;
  endtask
endmodule
`default_nettype wire

// File: girc_top_tb.sv
`default_nettype none
module girc_top_tb import girc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0, nrst = 1'b0, reg_wr, reg_rd, lookup_engine_irq;
  logic gpio_trig_irq, gpio_ts_irq, power_event_req, power_event_output;
  logic power_event_output_oe_n, irq_out_n, datapath_rst_n;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, v;
  logic [6:0]  port_irq;
  logic [15:0] zq[$] = '{16'h0006, 16'h0013, 16'h0014, 16'h001f, 16'h0040};
  int err_count = 0, n_checks = 0, gm, pm, i;
  always #10 clock = ~clock;
  girc_top u_girc_top (.*);
  girc_host u_girc_host (.*);
  task automatic chk(input string n, input logic [7:0] e, g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    {lookup_engine_irq, gpio_trig_irq, gpio_ts_irq, port_irq} = 10'h0;
    power_event_req = 1'b0;
    u_girc_host.idle();
    void'($urandom(32'h6c23));
    repeat (2) @(posedge clock);
    #1 nrst = 1'b1;
    u_girc_host.rd(GIRC_ADDR_REV, v);
    chk("rev", {GIRC_REV_DEFAULT, 4'h0}, v);
    foreach (zq[k]) begin
      u_girc_host.rd(zq[k], v);
      chk("reset", 8'h00, v);
    end
    $display("done reset");
    u_girc_host.wr(GIRC_ADDR_REV, 8'hff);
    u_girc_host.rd(GIRC_ADDR_REV, v);
    chk("srst", {GIRC_REV_DEFAULT, 4'h1}, v);
    u_girc_host.idle();
    repeat (8) @(posedge clock);
    chk("dp", 8'h00, {7'h0, datapath_rst_n});
    u_girc_host.wr(GIRC_ADDR_REV, 8'h00);
    u_girc_host.idle();
    chk("dp", 8'h01, {7'h0, datapath_rst_n});
    $display("done soft reset");
    for (int p = 0; p < 5; p++) begin
      u_girc_host.wr(GIRC_ADDR_PWR, {6'h0, p < 4, p[0]});
      power_event_req = p[1];
      u_girc_host.idle();
      repeat (5) @(posedge clock);
      #1;
      if (p < 4) chk("pwr", {7'h0, p[1] ~^ p[0]}, {6'h0, power_event_output_oe_n, power_event_output});
      else chk("oe", 8'h01, {7'h0, power_event_output_oe_n});
    end
    $display("done power event");
    repeat (16) begin
      gm = $urandom;
      pm = $urandom;
      {lookup_engine_irq, gpio_trig_irq, gpio_ts_irq, port_irq} = 10'($urandom);
      u_girc_host.wr(GIRC_ADDR_GMASK, gm[7:0]);
      u_girc_host.wr(GIRC_ADDR_PMASK + 16'h3, pm[7:0]);
      u_girc_host.rd(GIRC_ADDR_PMASK + 16'h3, v);
      chk("pmask", {1'b0, pm[6:0]}, v);
      u_girc_host.idle();
      repeat (5) @(posedge clock);
      #1;
      i = (lookup_engine_irq & !gm[7]) | ((gpio_trig_irq | gpio_ts_irq) & !gm[6]);
      i = i | (|(port_irq & ~pm[6:0]));
      chk("irq", {7'h0, !i[0]}, {7'h0, irq_out_n});
      u_girc_host.rd(GIRC_ADDR_GSTAT, v);
      chk("gstat", {lookup_engine_irq, gpio_trig_irq | gpio_ts_irq, 6'h0}, v);
      u_girc_host.rd(GIRC_ADDR_PSTAT + 16'h3, v);
      chk("pstat", {1'b0, port_irq}, v);
      u_girc_host.rd(GIRC_ADDR_GMASK, v);
      chk("gmask", {gm[7:6], 6'h0}, v);
    end
    $display("done interrupts");
    wrap_up();
  end
endmodule
bind girc_top girc_properties #(.NPORTS(NPORTS), .REVISION(REVISION)) u_girc_properties (.*);
`default_nettype wire
